// ==== shared/pscr_pkg.sv ====
// Package for the pack status and charger request block.
// Assumes one 125 MHz system clock. All timing is derived from that rate.
package pscr_pkg;

	// ------------------------------------------------------------
	// Clock and timing base
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 8;
	localparam int TICK_TIME_US    = 100;                              // Protection time base
	localparam int TICK_CYCLES     = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int TICKS_PER_MS    = 1000 / TICK_TIME_US;
	localparam int REQ_PERIOD_MS   = 100;
	localparam int REQ_PERIOD_TICKS = REQ_PERIOD_MS * TICKS_PER_MS;
	localparam int SC_TIME_US      = 300;
	localparam int SC_TICKS        = (SC_TIME_US + TICK_TIME_US - 1) / TICK_TIME_US;
	localparam int OC1_TIME_S      = 5;
	localparam int OC1_TICKS       = OC1_TIME_S * 1000 * TICKS_PER_MS;
	localparam int OC2_TIME_MS     = 50;
	localparam int OC2_TICKS       = OC2_TIME_MS * TICKS_PER_MS;
	localparam int OV_TIME_S       = 4;
	localparam int OV_TICKS        = OV_TIME_S * 1000 * TICKS_PER_MS;
	localparam int UV_TIME_S       = 2;
	localparam int UV_TICKS        = UV_TIME_S * 1000 * TICKS_PER_MS;

	// ------------------------------------------------------------
	// Thresholds (current in 1/16 A, voltage in 1/256 V)
	// ------------------------------------------------------------
	localparam int CURR_LSB_PER_A  = 16;
	localparam int SC_CURR_A       = 300;
	localparam int OC1_CURR_A      = 65;
	localparam int OC2_CURR_A      = 85;
	localparam logic [15:0] SC_RAW  = 16'(SC_CURR_A * CURR_LSB_PER_A);
	localparam logic [15:0] OC1_RAW = 16'(OC1_CURR_A * CURR_LSB_PER_A);
	localparam logic [15:0] OC2_RAW = 16'(OC2_CURR_A * CURR_LSB_PER_A);
	localparam int VOLT_LSB_PER_V  = 256;
	localparam int OV_LO_MV        = 29750;
	localparam int UV_LO_MV        = 18200;
	localparam int OV_HI_MV        = 59500;
	localparam int UV_HI_MV        = 36400;
	// Over-voltage rounds up, under-voltage rounds down: neither trips early
	localparam logic [15:0] OV_LO_RAW = 16'((OV_LO_MV * VOLT_LSB_PER_V + 999) / 1000);
	localparam logic [15:0] UV_LO_RAW = 16'((UV_LO_MV * VOLT_LSB_PER_V) / 1000);
	localparam logic [15:0] OV_HI_RAW = 16'((OV_HI_MV * VOLT_LSB_PER_V + 999) / 1000);
	localparam logic [15:0] UV_HI_RAW = 16'((UV_HI_MV * VOLT_LSB_PER_V) / 1000);

	// ------------------------------------------------------------
	// Status word layouts
	// ------------------------------------------------------------
	localparam int WRN_NODE_ID_EN   = 14;
	localparam int WRN_DEACT_EN     = 12;
	localparam int WRN_NET_FAIL     = 11;
	localparam int WRN_MAX_RECUP    = 7;
	localparam int WRN_TEMP_CHG     = 4;
	localparam int WRN_TEMP_DIS     = 3;
	localparam int WRN_RESERVE_SOC  = 2;
	localparam int WRN_LOW_SOC      = 1;
	localparam int WRN_LOW_VOLT     = 0;
	localparam logic [15:0] WRN_USED_MASK = 16'hD89F;                  // Bits 13,10..8,6,5 unused
	localparam int CHG_SUPPLY_RDY   = 15;
	localparam int CHG_MASTER_RDY   = 14;
	localparam int CHG_SW_TEMP_DIS  = 13;
	localparam int CHG_OUT_OFF      = 12;
	localparam int CHG_MAX_VOLT_REQ = 11;
	localparam int CHG_MAX_CURR_REQ = 10;
	localparam int CHG_CURR_HI_T    = 8;
	localparam int CHG_CURR_NORM_T  = 7;
	localparam int CHG_CURR_LO_T    = 6;
	localparam int CHG_CURR_KEEP    = 5;
	localparam int CHG_CURR_EN      = 4;
	localparam int CHG_VOLT_KEEP    = 1;
	localparam int CHG_VOLT_EN      = 0;
	localparam logic [15:0] CHG_USED_MASK = 16'hFDF3;                  // Bits 9,3,2 unused
	localparam int INF_FULL         = 6;
	localparam int INF_SW_CLOSED    = 2;
	localparam int INF_ALMOST_EMPTY = 1;
	localparam int INF_EMPTY        = 0;

	// ------------------------------------------------------------
	// Charger request message
	// ------------------------------------------------------------
	localparam logic [10:0] REQ_MSG_ID  = 11'h264;
	localparam logic [3:0]  REQ_MSG_DLC = 4'h8;
	localparam int BST_FULL     = 0;
	localparam int BST_TRIP     = 1;
	localparam int BST_SHUTDOWN = 2;

	typedef struct packed {
		logic [15:0] info;
		logic [15:0] warn;
		logic [15:0] err;
		logic [15:0] chg;
	} pscr_status_type;

	typedef struct packed {
		logic [10:0]     id;
		logic [3:0]      dlc;
		logic [7:0][7:0] data;                                          // data[0] is sent first
	} pscr_frame_type;

	typedef enum logic [2:0] {
		ST_CHARGE  = 3'b001,
		ST_STANDBY = 3'b010,
		ST_OFF     = 3'b100
	} pscr_state_type;

endpackage

// ==== rtl/pscr_qual_timer.sv ====
// Qualification timer: a condition must hold for a number of ticks to trip.
// Assumes tick is a one-cycle enable on clk_sys; trip stays until cleared.
module pscr_qual_timer #(
	parameter int W = 16
) (
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	input  wire logic         tick,
	input  wire logic         cond,
	input  wire logic [W-1:0] limit,
	input  wire logic         clear,
	output logic              trip
);
	logic [W-1:0] cnt_ff;
	logic         trip_ff;

	// ------------------------------------------------------------
	// Hold counter
	// ------------------------------------------------------------
	// Restarts whenever the condition drops, so only an unbroken run counts
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= '0;
		end else if (!cond) begin
			cnt_ff <= '0;
		end else if (tick && (cnt_ff != limit)) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	// Sticky trip; a new trip wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			trip_ff <= 1'b0;
		end else if (cond && tick && (cnt_ff == limit - 1'b1)) begin
			trip_ff <= 1'b1;
		end else if (clear) begin
			trip_ff <= 1'b0;
		end
	end

	assign trip = trip_ff;
endmodule

// ==== rtl/pscr_master.sv ====
// Battery pack master: system status summary, charger request framer,
// full-charge handover and protection trips.
// Assumes module status words, measurements and the frame sink share clk_sys.
module pscr_master #(
	parameter int NMOD     = 4,
	parameter int TICK_CYC = pscr_pkg::TICK_CYCLES
) (
	input  wire logic                                   clk_sys,
	input  wire logic                                   rstn,
	input  wire pscr_pkg::pscr_status_type [NMOD-1:0]   mod_status,
	input  wire logic                                   net_fail,
	input  wire logic [7:0]                             soc_pct,
	input  wire logic [7:0]                             reserve_soc_level,
	input  wire logic [7:0]                             low_soc_level,
	input  wire logic [15:0]                            low_volt_level,
	input  wire logic [15:0]                            meas_volt,
	input  wire logic [15:0]                            meas_curr,
	input  wire logic                                   meas_charging,
	input  wire logic                                   pack_variant_high,
	input  wire logic [15:0]                            req_volt,
	input  wire logic [15:0]                            req_curr,
	input  wire logic [15:0]                            standby_volt,
	input  wire logic [15:0]                            standby_curr,
	input  wire logic [15:0]                            keep_power_ms,
	input  wire logic                                   trip_clear,
	input  wire logic                                   frame_ready,
	output pscr_pkg::pscr_status_type                   summary,
	output pscr_pkg::pscr_frame_type                    frame,
	output logic                                        frame_valid,
	output logic                                        full_flag,
	output logic                                        standby,
	output logic                                        shutdown,
	output logic [6:0]                                  trips
);
	import pscr_pkg::*;

	localparam int TW = $clog2(TICK_CYC + 1);

	logic [TW-1:0]   tick_cnt_ff;
	logic            tick_ff;
	logic [15:0]     period_cnt_ff;
	logic [3:0]      ms_sub_ff;
	logic [15:0]     keep_cnt_ff;
	pscr_state_type  state_ff;
	pscr_state_type  nxt_state;
	pscr_status_type summary_ff;
	pscr_status_type nxt_summary;
	pscr_frame_type  frame_ff;
	pscr_frame_type  nxt_frame;
	logic            frame_valid_ff;
	logic            full_ff;
	logic            send_now;
	logic            ms_tick;
	logic            all_full;
	logic            any_trip;
	logic [6:0]      trip_w;
	logic [15:0]     ov_lim;
	logic [15:0]     uv_lim;
	logic [15:0]     tx_volt;
	logic [15:0]     tx_curr;
	logic [7:0]      batt_status;

	// ------------------------------------------------------------
	// Time base
	// ------------------------------------------------------------
	// One pulse per 100 us; every slower timer counts these pulses
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_ff <= '0;
			tick_ff     <= 1'b0;
		end else if (tick_cnt_ff == TW'(TICK_CYC - 1)) begin
			tick_cnt_ff <= '0;
			tick_ff     <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 1'b1;
			tick_ff     <= 1'b0;
		end
	end

	// Millisecond pulse for the keep-power delay
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ms_sub_ff <= '0;
		end else if (tick_ff) begin
			ms_sub_ff <= (ms_sub_ff == 4'(TICKS_PER_MS - 1)) ? 4'h0 : ms_sub_ff + 1'b1;
		end
	end
	assign ms_tick = tick_ff && (ms_sub_ff == 4'(TICKS_PER_MS - 1));

	// Request period counter
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			period_cnt_ff <= '0;
		end else if (tick_ff) begin
			period_cnt_ff <= send_now ? 16'h0000 : period_cnt_ff + 1'b1;
		end
	end
	assign send_now = tick_ff && (period_cnt_ff == 16'(REQ_PERIOD_TICKS - 1));

	// ------------------------------------------------------------
	// Protection trips
	// ------------------------------------------------------------
	assign ov_lim = pack_variant_high ? OV_HI_RAW : OV_LO_RAW;
	assign uv_lim = pack_variant_high ? UV_HI_RAW : UV_LO_RAW;

	// Order: short, dis 65, dis 85, chg 65, chg 85, over volt, under volt
	pscr_qual_timer #(.W(16)) u_sc (
		.clk_sys (clk_sys), .rstn (rstn), .tick (tick_ff), .clear (trip_clear),
		.cond    (!meas_charging && (meas_curr >= SC_RAW)),
		.limit   (16'(SC_TICKS)), .trip (trip_w[0])
	);
	pscr_qual_timer #(.W(16)) u_doc1 (
		.clk_sys (clk_sys), .rstn (rstn), .tick (tick_ff), .clear (trip_clear),
		.cond    (!meas_charging && (meas_curr >= OC1_RAW)),
		.limit   (16'(OC1_TICKS)), .trip (trip_w[1])
	);
	pscr_qual_timer #(.W(16)) u_doc2 (
		.clk_sys (clk_sys), .rstn (rstn), .tick (tick_ff), .clear (trip_clear),
		.cond    (!meas_charging && (meas_curr >= OC2_RAW)),
		.limit   (16'(OC2_TICKS)), .trip (trip_w[2])
	);
	pscr_qual_timer #(.W(16)) u_coc1 (
		.clk_sys (clk_sys), .rstn (rstn), .tick (tick_ff), .clear (trip_clear),
		.cond    (meas_charging && (meas_curr >= OC1_RAW)),
		.limit   (16'(OC1_TICKS)), .trip (trip_w[3])
	);
	pscr_qual_timer #(.W(16)) u_coc2 (
		.clk_sys (clk_sys), .rstn (rstn), .tick (tick_ff), .clear (trip_clear),
		.cond    (meas_charging && (meas_curr >= OC2_RAW)),
		.limit   (16'(OC2_TICKS)), .trip (trip_w[4])
	);
	pscr_qual_timer #(.W(16)) u_ov (
		.clk_sys (clk_sys), .rstn (rstn), .tick (tick_ff), .clear (trip_clear),
		.cond    (meas_volt >= ov_lim),
		.limit   (16'(OV_TICKS)), .trip (trip_w[5])
	);
	pscr_qual_timer #(.W(16)) u_uv (
		.clk_sys (clk_sys), .rstn (rstn), .tick (tick_ff), .clear (trip_clear),
		.cond    (meas_volt <= uv_lim),
		.limit   (16'(UV_TICKS)), .trip (trip_w[6])
	);
	assign any_trip = |trip_w;

	// ------------------------------------------------------------
	// Full-charge handover
	// ------------------------------------------------------------
	// Each module reports full on info bit 6 and opens its own switch
	assign all_full = summary_ff.info[INF_FULL];

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_CHARGE:  if (all_full) nxt_state = ST_STANDBY;
			ST_STANDBY: begin
				if (!all_full) begin
					nxt_state = ST_CHARGE;
				end else if (ms_tick && (keep_cnt_ff >= keep_power_ms)) begin
					nxt_state = ST_OFF;
				end
			end
			ST_OFF:     nxt_state = ST_OFF;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_CHARGE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Keep-power delay in ms; a zero delay still waits in standby for the next ms pulse
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			keep_cnt_ff <= '0;
		end else if (state_ff != ST_STANDBY) begin
			keep_cnt_ff <= 16'h0001;
		end else if (ms_tick && (keep_cnt_ff != 16'hFFFF)) begin
			keep_cnt_ff <= keep_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			full_ff <= 1'b0;
		end else begin
			full_ff <= all_full;
		end
	end

	// ------------------------------------------------------------
	// System summary
	// ------------------------------------------------------------
	// Registered once per cycle so the frame and flags see a stable word
	always_comb begin
		nxt_summary.info = '1;
		nxt_summary.warn = '0;
		nxt_summary.err  = '0;
		nxt_summary.chg  = '0;
		for (int i = 0; i < NMOD; i++) begin
			nxt_summary.info = nxt_summary.info & mod_status[i].info;
			nxt_summary.warn = nxt_summary.warn | mod_status[i].warn;
			nxt_summary.err  = nxt_summary.err  | mod_status[i].err;
			nxt_summary.chg  = nxt_summary.chg  | mod_status[i].chg;
		end
		nxt_summary.warn[WRN_NET_FAIL]    = nxt_summary.warn[WRN_NET_FAIL] | net_fail;
		nxt_summary.warn[WRN_RESERVE_SOC] = (soc_pct <= reserve_soc_level);
		nxt_summary.warn[WRN_LOW_SOC]     = (soc_pct <= low_soc_level);
		nxt_summary.warn[WRN_LOW_VOLT]    = (meas_volt <= low_volt_level);
		// Unused positions are forced low whatever a module sends
		nxt_summary.warn = nxt_summary.warn & WRN_USED_MASK;
		nxt_summary.chg[CHG_OUT_OFF]   = nxt_summary.chg[CHG_OUT_OFF] | any_trip
			| (state_ff == ST_OFF);
		nxt_summary.chg[CHG_CURR_KEEP] = nxt_summary.chg[CHG_CURR_KEEP]
			| (state_ff == ST_STANDBY);
		nxt_summary.chg[CHG_VOLT_KEEP] = nxt_summary.chg[CHG_VOLT_KEEP]
			| (state_ff == ST_STANDBY);
		nxt_summary.chg = nxt_summary.chg & CHG_USED_MASK;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			summary_ff <= '0;
		end else begin
			summary_ff <= nxt_summary;
		end
	end

	// ------------------------------------------------------------
	// Charger request framer
	// ------------------------------------------------------------
	// Standby sends the standby value; off and trips request nothing
	always_comb begin
		if ((state_ff == ST_OFF) || any_trip) begin
			tx_volt = 16'h0000;
			tx_curr = 16'h0000;
		end else if (state_ff == ST_STANDBY) begin
			tx_volt = standby_volt;
			tx_curr = standby_curr;
		end else begin
			tx_volt = req_volt;
			tx_curr = req_curr;
		end
	end

	always_comb begin
		batt_status               = 8'h00;
		batt_status[BST_FULL]     = full_ff;
		batt_status[BST_TRIP]     = any_trip;
		batt_status[BST_SHUTDOWN] = (state_ff == ST_OFF);
	end

	always_comb begin
		nxt_frame.id      = REQ_MSG_ID;
		nxt_frame.dlc     = REQ_MSG_DLC;
		nxt_frame.data[0] = summary_ff.chg[7:0];
		nxt_frame.data[1] = soc_pct;
		nxt_frame.data[2] = 8'h00;
		nxt_frame.data[3] = tx_volt[7:0];
		nxt_frame.data[4] = tx_volt[15:8];
		nxt_frame.data[5] = tx_curr[7:0];
		nxt_frame.data[6] = tx_curr[15:8];
		nxt_frame.data[7] = batt_status;
	end

	// A frame still waiting when the next period comes is refreshed in place,
	// since the charger only acts on the most recent request
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			frame_ff <= '0;
		end else if (send_now) begin
			frame_ff <= nxt_frame;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			frame_valid_ff <= 1'b0;
		end else if (send_now) begin
			frame_valid_ff <= 1'b1;
		end else if (frame_ready) begin
			frame_valid_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign summary     = summary_ff;
	assign frame       = frame_ff;
	assign frame_valid = frame_valid_ff;
	assign full_flag   = full_ff;
	assign standby     = (state_ff == ST_STANDBY);
	assign shutdown    = (state_ff == ST_OFF);
	assign trips       = trip_w;
endmodule

// ==== verification/pscr_master_props.sv ====
// Checker for the pack master summary, request frame and trips.
// Assumes it is bound to pscr_master and only watches its ports.
module pscr_master_props #(
	parameter int NMOD     = 4,
	parameter int TICK_CYC = pscr_pkg::TICK_CYCLES
) (
	input wire logic                                 clk_sys,
	input wire logic                                 rstn,
	input wire pscr_pkg::pscr_status_type [NMOD-1:0] mod_status,
	input wire logic                                 net_fail,
	input wire logic [15:0]                          meas_curr,
	input wire logic                                 meas_charging,
	input wire logic                                 frame_ready,
	input wire pscr_pkg::pscr_status_type            summary,
	input wire pscr_pkg::pscr_frame_type             frame,
	input wire logic                                 frame_valid,
	input wire logic                                 full_flag,
	input wire logic                                 shutdown,
	input wire logic [6:0]                           trips
);
	import pscr_pkg::*;
	logic [15:0] and_inf;
	logic [15:0] or_err;
	logic [15:0] or_wrn;
	logic [15:0] sc_cnt_ff;
	// Reference combination of the module words
	always_comb begin
		and_inf = 16'hFFFF;
		or_err  = 16'h0000;
		or_wrn  = 16'(net_fail) << WRN_NET_FAIL;
		for (int i = 0; i < NMOD; i++) begin
			and_inf &= mod_status[i].info;
			or_err  |= mod_status[i].err;
			or_wrn  |= mod_status[i].warn;
		end
	end
	// Unbroken short-circuit cycles; the bench keeps it far from wrapping
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			sc_cnt_ff <= 16'h0000;
		else if (meas_curr >= SC_RAW && !meas_charging)
			sc_cnt_ff <= sc_cnt_ff + 16'h0001;
		else
			sc_cnt_ff <= 16'h0000;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_unused_zero: assert property ((summary.warn & ~WRN_USED_MASK) == 0 && summary.chg[9] == 0 && summary.chg[3] == 0)
		else $error("unused status bit set");
	a_info_and: assert property ($past(rstn) |-> summary.info == $past(and_inf))
		else $error("info summary not the AND of modules");
	a_err_or: assert property ($past(rstn) |-> summary.err == $past(or_err))
		else $error("error summary not the OR of modules");
	a_warn_or: assert property ($past(rstn) |-> summary.warn[15:3] == ($past(or_wrn[15:3]) & WRN_USED_MASK[15:3]))
		else $error("warning summary upper bits wrong");
	a_full_follow: assert property (full_flag == $past(summary.info[INF_FULL]))
		else $error("full flag does not follow summary");
	a_off_sticky: assert property (shutdown |=> shutdown)
		else $error("shutdown left without reset");
	a_frame_hold: assert property (frame_valid && !frame_ready |=> frame_valid)
		else $error("frame withdrawn before acceptance");
	a_frame_hdr: assert property (frame_valid |-> frame.id == REQ_MSG_ID && frame.dlc == REQ_MSG_DLC && frame.data[7][7:3] == 0)
		else $error("frame header or status byte wrong");
	a_sc_early: assert property ($rose(trips[0]) |-> sc_cnt_ff >= 16'(2 * TICK_CYC - 2))
		else $error("short trip too early");
	a_sc_late: assert property (sc_cnt_ff >= 16'(4 * TICK_CYC) |-> trips[0])
		else $error("short trip missing");
endmodule

bind pscr_master pscr_master_props #(.NMOD(NMOD), .TICK_CYC(TICK_CYC)) u_pscr_master_props (.clk_sys, .rstn,
	.mod_status, .net_fail, .meas_curr, .meas_charging, .frame_ready, .summary, .frame, .frame_valid,
	.full_flag, .shutdown, .trips);

// ==== verification/pscr_charger_model.sv ====
// Charger model: takes request frames after a stall, keeps the latest ones.
// Assumes frame and frame_valid come from pscr_master on clk_sys.
module pscr_charger_model #(
	parameter int STALL = 3
) (
	input wire logic                     clk_sys,
	input wire logic                     rstn,
	input wire pscr_pkg::pscr_frame_type frame,
	input wire logic                     frame_valid,
	output logic                         frame_ready,
	output logic [15:0]                  rx_volt_ff,
	output logic [15:0]                  rx_curr_ff,
	output logic [7:0]                   rx_cnt_ff
);
	import pscr_pkg::*;
	int wait_ff;
	// Slow sink: ready only after a stall, so the master must hold its frame
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			frame_ready <= 1'b0;
			wait_ff     <= 0;
			rx_volt_ff  <= 16'h0000;
			rx_curr_ff  <= 16'h0000;
			rx_cnt_ff   <= 8'h00;
		end else if (frame_ready && frame_valid) begin
			frame_ready <= 1'b0;
			wait_ff     <= 0;
			rx_volt_ff  <= {frame.data[4], frame.data[3]};
			rx_curr_ff  <= {frame.data[6], frame.data[5]};
			rx_cnt_ff   <= rx_cnt_ff + 8'h01;
		end else if (frame_valid && wait_ff >= STALL) begin
			frame_ready <= 1'b1;
		end else if (frame_valid) begin
			wait_ff <= wait_ff + 1;
		end
	end
endmodule

// ==== verification/pscr_master_bench.sv ====
// Bench for the pack master: summary, trips, request frames, handover.
// Assumes a 125 MHz clock and a tick shortened to 10 cycles.
module pscr_master_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import pscr_pkg::*;
	localparam int NM = 4;
	localparam int TC = 10;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	pscr_status_type [NM-1:0] mod_status = '0;
	logic net_fail = 1'b0;
	logic [7:0] soc_pct = 8'h50;
	logic [7:0] reserve_soc_level = 8'h00;
	logic [7:0] low_soc_level = 8'h00;
	logic [15:0] meas_volt = 16'h1400;
	logic [15:0] low_volt_level = 16'h1300;
	logic [15:0] meas_curr = 16'h0000;
	logic meas_charging = 1'b0;
	logic pack_variant_high = 1'b0;
	logic [15:0] req_volt = 16'h0000;
	logic [15:0] req_curr = 16'h0000;
	logic [15:0] standby_volt = 16'h0D00;
	logic [15:0] standby_curr = 16'h0010;
	logic [15:0] keep_power_ms = 16'h0000;
	logic trip_clear = 1'b0;
	logic frame_ready, frame_valid, full_flag, standby, shutdown;
	pscr_status_type summary;
	pscr_frame_type frame;
	logic [6:0] trips;
	logic [15:0] cv, cc, e_chg;
	logic [7:0] got;
	int ncyc = 0;
	int error_cnt = 0;
	int num_checks = 0;
	pscr_master #(.NMOD(NM), .TICK_CYC(TC)) u_pscr_master (.clk_sys, .rstn, .mod_status, .net_fail, .soc_pct,
		.reserve_soc_level, .low_soc_level, .low_volt_level, .meas_volt, .meas_curr, .meas_charging,
		.pack_variant_high, .req_volt, .req_curr, .standby_volt, .standby_curr, .keep_power_ms, .trip_clear,
		.frame_ready, .summary, .frame, .frame_valid, .full_flag, .standby, .shutdown, .trips);
	pscr_charger_model #(.STALL(3)) u_pscr_charger_model (.clk_sys, .rstn, .frame, .frame_valid, .frame_ready,
		.rx_volt_ff(cv), .rx_curr_ff(cc), .rx_cnt_ff(got));
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) ncyc <= ncyc + 1;
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Outputs are only compared mid-cycle, once the edge's updates landed
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wait_got();
		logic [7:0] g;
		g = got;
		for (int w = 0; w < 20000 && got === g; w++)
			@(posedge clk_sys);
	endtask
	task automatic t_summary();
		pscr_status_type m;
		logic [15:0] ei, ew, ee;
		ei = 16'hFFFF;
		{ew, ee, e_chg} = '0;
		@(posedge clk_sys);
		for (int i = 0; i < NM; i++) begin
			m = {~(16'h0041 << i), 16'h3327 << i, 16'h0001 << (4 * i), 16'h0219 << i};
			mod_status[i] <= m;
			ei &= m.info;
			ew |= m.warn;
			ee |= m.err;
			e_chg |= m.chg;
		end
		e_chg &= CHG_USED_MASK;
		net_fail <= 1'b1;
		soc_pct <= 8'h10;
		low_soc_level <= 8'h14;
		reserve_soc_level <= 8'h05;
		cyc(2);
		@(negedge clk_sys);
		chk(summary.info, ei);
		chk(summary.err, ee);
		chk(summary.warn, (ew & WRN_USED_MASK & 16'hFFF8) | 16'h0802);
		chk(summary.chg, e_chg);
		$display("test summary done");
	endtask
	task automatic t_trips();
		@(posedge clk_sys);
		// Drop the module output-off bit so only the master can raise it
		mod_status[3].chg <= 16'h00C8;
		meas_curr <= SC_RAW;
		cyc(2 * TC - 4);
		@(negedge clk_sys);
		chk(16'(trips), 16'h0000);
		chk(16'(summary.chg[CHG_OUT_OFF]), 16'h0000);
		cyc(2 * TC + 8);
		@(negedge clk_sys);
		chk(16'(trips), 16'h0001);
		chk(16'(summary.chg[CHG_OUT_OFF]), 16'h0001);
		for (int d = 0; d < 3; d++) begin
			@(posedge clk_sys);
			meas_curr <= 16'h0000;
			trip_clear <= 1'b1;
			@(posedge clk_sys);
			trip_clear <= 1'b0;
			cyc(2 * TC);
			if (d == 2)
				break;
			meas_curr <= OC2_RAW;
			meas_charging <= d[0];
			cyc((OC2_TICKS - 2) * TC);
			@(negedge clk_sys);
			chk(16'(trips), 16'h0000);
			cyc(4 * TC);
			@(negedge clk_sys);
			chk(16'(trips), d[0] ? 16'h0010 : 16'h0004);
		end
		@(negedge clk_sys);
		chk(16'(trips), 16'h0000);
		$display("test trips done");
	endtask
	task automatic t_frame();
		int t0;
		@(posedge clk_sys);
		req_volt <= 16'h1E19;
		req_curr <= 16'h0240;
		wait_got();
		t0 = ncyc;
		wait_got();
		chk(16'(ncyc - t0), 16'(REQ_PERIOD_TICKS * TC));
		@(negedge clk_sys);
		chk(cv, 16'h1E19);
		chk(cc, 16'h0240);
		chk({frame.data[1], frame.data[0]}, {8'h10, e_chg[7:0]});
		chk({frame.data[7], frame.data[2]}, 16'h0000);
		$display("test frame done");
	endtask
	task automatic t_full();
		int t0;
		@(posedge clk_sys);
		keep_power_ms <= 16'h00C8;
		// Full modules with their switches open and no charge flags of their own
		for (int i = 0; i < NM; i++)
			mod_status[i] <= {16'h0040, 16'h0000, 16'h0000, 16'h0000};
		cyc(3);
		@(negedge clk_sys);
		t0 = ncyc;
		chk(16'({full_flag, standby}), 16'h0003);
		chk(summary.chg, 16'h0022);
		// Skip any frame launched before standby, then take one sent in it
		cyc(10);
		wait_got();
		@(negedge clk_sys);
		chk(cv, 16'h0D00);
		chk(cc, 16'h0010);
		chk(16'(frame.data[7]), 16'h0001);
		chk(16'(shutdown), 16'h0000);
		for (int w = 0; w < 12000 && shutdown !== 1'b1; w++)
			@(negedge clk_sys);
		chk(16'((ncyc - t0) / (10 * TC)), 16'h00C7);
		cyc(1);
		@(negedge clk_sys);
		chk(16'({shutdown, summary.chg[CHG_OUT_OFF]}), 16'h0003);
		$display("test full done");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence; handover last because shutdown holds until reset
	initial begin
		cyc(20);
		rstn <= 1'b1;
		cyc(2);
		t_summary();
		t_trips();
		t_frame();
		t_full();
		test_done();
	end
	// Watchdog well past the roughly 50000 cycles the tests need
	initial begin
		cyc(70000);
		error_cnt++;
		test_done();
	end
endmodule
